// File: design/sar_adc_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: mclk at 250 MHz
// Notes:   host-side times are kept for the bench; the device does not enforce them
`default_nettype none
package sar_adc_pkg;

  // ==========================================================
  // widths and reset values
  localparam int               RESULT_WIDTH = 14;
  localparam logic [13:0]      RESULT_RESET = 14'h0000;
  localparam logic [3:0]       MSB_INDEX    = 4'hd;

  // ==========================================================
  // timing
  localparam int MCLK_MHZ           = 250;
  // one bit decision, internal conversion clock; least time, rounded up
  localparam int BIT_TIME_NS        = 120;
  localparam int BIT_CYCLES         = (BIT_TIME_NS * MCLK_MHZ + 999) / 1000;
  // host side: least acquire time and typical wake-up time
  localparam int ACQUIRE_MIN_NS     = 400;
  localparam int ACQUIRE_MIN_CYCLES = (ACQUIRE_MIN_NS * MCLK_MHZ + 999) / 1000;
  localparam int WAKE_NS            = 400;
  localparam int WAKE_CYCLES        = (WAKE_NS * MCLK_MHZ + 999) / 1000;
  // host side: start input back high within this time of a start
  localparam int START_HIGH_NS      = 900;
  localparam int START_HIGH_CYCLES  = (START_HIGH_NS * MCLK_MHZ) / 1000;

  // ==========================================================
  // types
  typedef struct packed {
    logic chipSelectN;
    logic readN;
    logic conversionStartN;
    logic powerDownN;
  } host_pins_t;

  typedef enum {ACQUIRE, CONVERT, PUSH, DELIVER, NAP, SLEEP} conv_state_t;

endpackage
`default_nettype wire

// File: design/two_entry_buffer.sv
// Purpose: two-word buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   inReady is low only when both entries are full
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 14
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  logic [WIDTH-1:0] slot [2];
  logic             wrPtr;
  logic             rdPtr;
  logic [1:0]       count;
  logic             doPush;
  logic             doPop;

  // ==========================================================
  // handshake
  assign inReady  = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData  = slot[rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  // storage needs no reset; count guards every read
  always_ff @(posedge mclk)
  begin
    if (doPush)
      slot[wrPtr] <= inData;
  end

  // pointers and fill level
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (doPush)
        wrPtr <= ~wrPtr;
      if (doPop)
        rdPtr <= ~rdPtr;
      if (doPush && !doPop)
        count <= count + 2'h1;
      else if (doPop && !doPush)
        count <= count - 2'h1;
    end
  end

endmodule
`default_nettype wire

// File: design/sar_adc_control.sv
// Purpose: control and parallel result port of a 14-bit sampling converter
// Assumes: host pins and comparator are asynchronous to mclk
// Notes:   bit timing comes from mclk alone; no conversion clock from the host
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control #(
  parameter int BIT_CYCLES = sar_adc_pkg::BIT_CYCLES
) (
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire sar_adc_pkg::host_pins_t hostPins,
  input  wire logic                    compareHigh,
  output logic                         busyN,
  output logic [13:0]                  resultBus,
  output logic                         resultBusOe,
  output logic [13:0]                  trialDac,
  output logic                         acquirePhase,
  output logic                         napMode,
  output logic                         sleepMode
);

  localparam int TW = $clog2(BIT_CYCLES + 1);
  localparam int LAST_TICK = BIT_CYCLES - 1;

  sar_adc_pkg::host_pins_t  pinsMeta;
  sar_adc_pkg::host_pins_t  pins;
  sar_adc_pkg::conv_state_t state;
  sar_adc_pkg::conv_state_t next_state;
  logic          cmpMeta;
  logic          cmpSync;
  logic          startPrev;
  logic          powerPrev;
  logic          startEdge;
  logic          powerFell;
  logic [13:0]   bitTrial;
  logic [3:0]    bitIndex;
  logic [TW-1:0] bitTimer;
  logic          lastTick;
  logic [13:0]   codeWord;
  logic          bufInReady;
  logic          bufOutValid;
  logic          bufOutReady;
  logic [13:0]   bufOutData;
  logic          latchLoaded;

  // ==========================================================
  // input synchronisers
  // two flops per pin; only the second stage is looked at
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pinsMeta <= '1;
      pins     <= '1;
      cmpMeta  <= 1'b0;
      cmpSync  <= 1'b0;
    end
    else
    begin
      pinsMeta <= hostPins;
      pins     <= pinsMeta;
      cmpMeta  <= compareHigh;
      cmpSync  <= cmpMeta;
    end
  end

  // edge history of the synchronised levels
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      startPrev <= 1'b1;
      powerPrev <= 1'b1;
    end
    else
    begin
      startPrev <= pins.conversionStartN;
      powerPrev <= pins.powerDownN;
    end
  end

  // start counts only with select low
  assign startEdge = startPrev && !pins.conversionStartN && !pins.chipSelectN;
  assign powerFell = powerPrev && !pins.powerDownN;
  assign lastTick  = (bitTimer == TW'(LAST_TICK));

  // ==========================================================
  // conversion sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      sar_adc_pkg::ACQUIRE:
        if (startEdge)
          next_state = sar_adc_pkg::CONVERT;
      sar_adc_pkg::CONVERT:
        // start edges are not looked at here
        if (lastTick && bitIndex == 4'h0)
          next_state = sar_adc_pkg::PUSH;
      sar_adc_pkg::PUSH:
        // a full buffer stalls here with status still low
        if (bufInReady)
          next_state = sar_adc_pkg::DELIVER;
      sar_adc_pkg::DELIVER:
        if (latchLoaded)
          next_state = sar_adc_pkg::ACQUIRE;
      sar_adc_pkg::NAP,
      sar_adc_pkg::SLEEP:
        if (pins.powerDownN)
          next_state = sar_adc_pkg::ACQUIRE;
    endcase
    // shutdown overrides everything, even a conversion under way
    if (powerFell)
      next_state = pins.chipSelectN ? sar_adc_pkg::SLEEP : sar_adc_pkg::NAP;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      state <= sar_adc_pkg::ACQUIRE;
    else
      state <= next_state;
  end

  // mode and phase outputs, registered from the next state
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      napMode      <= 1'b0;
      sleepMode    <= 1'b0;
      acquirePhase <= 1'b1;
    end
    else
    begin
      napMode      <= (next_state == sar_adc_pkg::NAP);
      sleepMode    <= (next_state == sar_adc_pkg::SLEEP);
      acquirePhase <= (next_state == sar_adc_pkg::ACQUIRE);
    end
  end

  // ==========================================================
  // bit timing from mclk only
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      bitTimer <= '0;
      bitIndex <= sar_adc_pkg::MSB_INDEX;
    end
    else if (state != sar_adc_pkg::CONVERT)
    begin
      bitTimer <= '0;
      bitIndex <= sar_adc_pkg::MSB_INDEX;
    end
    else if (lastTick)
    begin
      bitTimer <= '0;
      bitIndex <= bitIndex - 4'h1;
    end
    else
      bitTimer <= bitTimer + TW'(1);
  end

  // trial register drives the capacitive DAC directly
  always_ff @(posedge mclk)
  begin
    if (reset)
      bitTrial <= sar_adc_pkg::RESULT_RESET;
    else if (state == sar_adc_pkg::ACQUIRE && next_state == sar_adc_pkg::CONVERT)
      bitTrial <= sar_adc_pkg::RESULT_RESET;
    else if (state == sar_adc_pkg::CONVERT)
    begin
      if (bitTimer == '0)
        bitTrial[bitIndex] <= 1'b1;
      else if (lastTick && !cmpSync)
        bitTrial[bitIndex] <= 1'b0;
    end
  end

  assign trialDac = bitTrial;
  // offset binary to two's complement: invert the top bit
  assign codeWord = {~bitTrial[13], bitTrial[12:0]};

  // ==========================================================
  // result path: buffer, then the output latches
  two_entry_buffer #(
    .WIDTH (sar_adc_pkg::RESULT_WIDTH)
  ) resultBuffer (
    .mclk     (mclk),
    .reset    (reset),
    .inValid  (state == sar_adc_pkg::PUSH),
    .inReady  (bufInReady),
    .inData   (codeWord),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // never change the latches under a read in progress
  assign bufOutReady = !resultBusOe;

  // whole word into the latches at once
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      resultBus   <= sar_adc_pkg::RESULT_RESET;
      latchLoaded <= 1'b0;
    end
    else
    begin
      latchLoaded <= bufOutValid && bufOutReady;
      if (bufOutValid && bufOutReady)
        resultBus <= bufOutData;
    end
  end

  // drivers on only with read and select both low
  always_ff @(posedge mclk)
  begin
    if (reset)
      resultBusOe <= 1'b0;
    else
      resultBusOe <= !pins.readN && !pins.chipSelectN;
  end

  // status: low from start until the latches hold the word
  always_ff @(posedge mclk)
  begin
    if (reset)
      busyN <= 1'b1;
    else if (next_state == sar_adc_pkg::CONVERT && state == sar_adc_pkg::ACQUIRE)
      busyN <= 1'b0;
    else if (next_state == sar_adc_pkg::ACQUIRE || next_state == sar_adc_pkg::NAP
             || next_state == sar_adc_pkg::SLEEP)
      busyN <= 1'b1;
  end

  // ==========================================================
  // checks
  logic [13:0] pushedWord;
  always_ff @(posedge mclk)
  begin
    if (reset)
      pushedWord <= sar_adc_pkg::RESULT_RESET;
    else if (state == sar_adc_pkg::PUSH && bufInReady)
      pushedWord <= codeWord;
  end

  property p_shutdown;
    @(posedge mclk) disable iff (reset)
    powerFell |=> (state == sar_adc_pkg::NAP || state == sar_adc_pkg::SLEEP);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not entered");

  property p_mode_pick;
    @(posedge mclk) disable iff (reset)
    powerFell |=> (napMode == !$past(pins.chipSelectN)) && (sleepMode == $past(pins.chipSelectN));
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("wrong shutdown mode");

  property p_deselected_start;
    @(posedge mclk) disable iff (reset)
    state == sar_adc_pkg::ACQUIRE && pins.chipSelectN |=> state != sar_adc_pkg::CONVERT;
  endproperty
  a_deselected_start: assert property (p_deselected_start) else $error("start while deselected");

  property p_drive_enable;
    @(posedge mclk) disable iff (reset)
    ##1 resultBusOe == (!$past(pins.readN) && !$past(pins.chipSelectN));
  endproperty
  a_drive_enable: assert property (p_drive_enable) else $error("bus enable wrong");

  property p_start;
    @(posedge mclk) disable iff (reset)
    state == sar_adc_pkg::ACQUIRE && startEdge && !powerFell
      |=> state == sar_adc_pkg::CONVERT && !busyN ##1 bitTrial[13];
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_busy_low;
    @(posedge mclk) disable iff (reset)
    state == sar_adc_pkg::CONVERT |-> !busyN && !acquirePhase;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("status high in conversion");

  property p_data_ready;
    @(posedge mclk) disable iff (reset)
    $rose(busyN) && !napMode && !sleepMode |-> resultBus == pushedWord;
  endproperty
  a_data_ready: assert property (p_data_ready) else $error("result not ready");

  property p_clear;
    @(posedge mclk) disable iff (reset)
    state == sar_adc_pkg::ACQUIRE && next_state == sar_adc_pkg::CONVERT |=> bitTrial == 14'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("trial not cleared");

  property p_no_restart;
    @(posedge mclk) disable iff (reset)
    state == sar_adc_pkg::CONVERT && startEdge && !powerFell && !lastTick
      |=> state == sar_adc_pkg::CONVERT && bitTimer == $past(bitTimer) + TW'(1);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted");

  property p_bit_order;
    @(posedge mclk) disable iff (reset)
    state == sar_adc_pkg::CONVERT && lastTick && bitIndex != 4'h0 && !powerFell
      |=> bitIndex == $past(bitIndex) - 4'h1;
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("bit order wrong");

endmodule
`default_nettype wire

// File: bench/analog_source_model.sv
// Purpose: comparator stand-in facing the trial word
// Assumes: target held still while a conversion runs
// Notes:   unsynchronised on purpose; the block owns the two-flop sync
`timescale 1ns/10ps
`default_nettype none
module analog_source_model (
  input  wire logic [13:0] target,
  input  wire logic [13:0] trialDac,
  output logic             compareHigh
);
  // ==========================================================
  // compare
  // input at or above the trial keeps the bit
  assign compareHigh = (target >= trialDac);
endmodule
`default_nettype wire

// File: bench/test_sar_adc_control.sv
// Purpose: self-checking bench of the converter control block
// Assumes: short bit period so a run stays brief
// Notes:   expected words come from an integer difference model
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_control;
  // ==========================================================
  // signals
  localparam int           BC = 4;
  logic                    mclk = 1'b0;
  logic                    reset = 1'b1;
  sar_adc_pkg::host_pins_t hostPins = 4'hf;
  logic [13:0]             target = 14'h0000;
  logic                    compareHigh;
  logic                    busyN;
  logic                    resultBusOe;
  logic                    acquirePhase;
  logic                    napMode;
  logic                    sleepMode;
  logic [13:0]             resultBus;
  logic [13:0]             trialDac;
  wire  [13:0]             dataWire = resultBusOe ? resultBus : 14'hzzzz;
  int                      n_fail = 0;
  int                      cmp_count = 0;
  logic [16:0]             lfsr = 17'h1234d;
  logic [13:0]             expQ[$];

  // clock flips each half period
  always #2 mclk = ~mclk;

  sar_adc_control #(.BIT_CYCLES(BC)) DUT (
    .mclk(mclk), .reset(reset), .hostPins(hostPins), .compareHigh(compareHigh),
    .busyN(busyN), .resultBus(resultBus), .resultBusOe(resultBusOe), .trialDac(trialDac),
    .acquirePhase(acquirePhase), .napMode(napMode), .sleepMode(sleepMode));

  analog_source_model SRC (.target(target), .trialDac(trialDac), .compareHigh(compareHigh));

  // ==========================================================
  // helpers
  function automatic logic [16:0] nextRand(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic close_out();
    $display("TB: compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chkWord(input logic [13:0] got, input logic [13:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chkFlag(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // pin order: select, read, start, power-down, all active low
  task automatic pins(input logic cs, input logic rd, input logic cv, input logic pd);
    @(posedge mclk);
    hostPins <= {cs, rd, cv, pd};
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // bounded wait; running out ends the run as a failure
  task automatic waitBusy(input logic lvl, input int bound, output int n);
    n = 0;
    do
    begin
      settle(1);
      n++;
    end
    while (busyN !== lvl && n < bound);
    if (busyN !== lvl)
    begin
      n_fail++;
      $display("[ERR] %0t busy wait ran out", $time);
      close_out();
    end
  endtask

  // ==========================================================
  // one conversion, optional second start mid-way, then a read
  task automatic convert(input logic [13:0] t, input bit again);
    int n;
    int diff;
    diff = int'(t) - 8192;
    expQ.push_back(diff[13:0]);
    target <= t;
    pins(1'b0, 1'b1, 1'b0, 1'b1);
    waitBusy(1'b0, 6, n);
    chkWord(trialDac, 14'h0000, "trial clear");
    chkFlag(acquirePhase, 1'b0, "hold phase");
    settle(1);
    chkWord(trialDac, 14'h2000, "msb trial first");
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    if (again)
    begin
      repeat (BC) @(posedge mclk);
      pins(1'b0, 1'b1, 1'b0, 1'b1);
      pins(1'b0, 1'b1, 1'b1, 1'b1);
    end
    waitBusy(1'b1, 14 * BC + 40, n);
    chkFlag(n > 12 * BC, 1'b1, "busy low whole conversion");
    chkWord(resultBus, expQ[0], "latch before busy rise");
    chkFlag(acquirePhase, 1'b1, "track phase");
    settle(10);
    chkFlag(busyN, 1'b1, "no restart");
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    settle(4);
    chkFlag(resultBusOe, 1'b1, "drivers on");
    chkWord(dataWire, expQ.pop_front(), "result word");
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    settle(4);
    chkWord(dataWire, 14'hzzzz, "bus released");
    repeat (sar_adc_pkg::ACQUIRE_MIN_CYCLES) @(posedge mclk);
  endtask

  // shutdown entered with select at level cs
  task automatic shut(input logic cs);
    pins(cs, 1'b1, 1'b1, 1'b1);
    pins(cs, 1'b1, 1'b1, 1'b0);
    settle(6);
    chkFlag(napMode, ~cs, "nap entry");
    chkFlag(sleepMode, cs, "sleep entry");
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    settle(8);
    chkFlag(busyN, 1'b1, "start refused in shutdown");
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    settle(6);
    chkFlag(napMode | sleepMode, 1'b0, "wake");
    repeat (sar_adc_pkg::WAKE_CYCLES) @(posedge mclk);
    $display("TB: shutdown test done");
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [13:0] edges[4];
    edges = '{14'h0000, 14'h3fff, 14'h2000, 14'h1fff};
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    foreach (edges[i])
      convert(edges[i], 1'b0);
    $display("TB: boundary test done");
    for (int i = 0; i < 6; i++)
    begin
      lfsr = nextRand(lfsr);
      convert(lfsr[13:0], i == 2);
    end
    $display("TB: random and restart test done");
    pins(1'b1, 1'b1, 1'b0, 1'b1);
    settle(10);
    chkFlag(busyN, 1'b1, "start ignored unselected");
    pins(1'b1, 1'b0, 1'b1, 1'b1);
    settle(6);
    chkFlag(resultBusOe, 1'b0, "read ignored unselected");
    $display("TB: select test done");
    // shutdown shortly after a start abandons the conversion
    pins(1'b0, 1'b1, 1'b0, 1'b1);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    settle(8);
    chkFlag(busyN, 1'b1, "abort on shutdown");
    chkFlag(napMode, 1'b1, "abort into nap");
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    repeat (sar_adc_pkg::WAKE_CYCLES) @(posedge mclk);
    $display("TB: abort test done");
    shut(1'b0);
    shut(1'b1);
    convert(14'h0155, 1'b0);
    $display("TB: final conversion test done");
    close_out();
  end
endmodule
`default_nettype wire
